// *** design/mcc_cmd.sv ***
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mcc_cmd
  import mcc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // applied settings
  output logic [3:0]       ch_enable,
  output logic             filter_50hz,
  output logic             fast_mode
);

  typedef enum {ST_IDLE, ST_FETCH, ST_WAIT, ST_LATCH, ST_EXEC, ST_DONE} mcc_state_t;

  mcc_state_t state;
  logic [7:0] node_addr;
  logic [7:0] misc;
  logic [3:0] rx_len;
  logic [2:0] rd_idx;
  logic [7:0] req [4];
  logic [7:0] resp [4];
  logic [2:0] resp_len;
  logic       resp_ready;
  logic       resp_drop;
  logic       overflow;
  logic [3:0] frame_cnt;
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] wstrb_q;
  logic       wr_go;
  logic [31:0] next_rdata;
  logic       next_rerr;

  mcc_mem_if #(.AW(BUF_AW)) mem ();

  mcc_frame_mem #(.DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_mem
  (
    .aclk (aclk),
    .mp   (mem.mem)
  );

  function automatic logic addr_ok(input logic [7:0] a);
    return (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction : addr_ok

  // write channel capture: address and data in either order
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_q     <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_q == REG_RX || aw_q == REG_CTRL || aw_q == REG_ADDR || aw_q == REG_CONFIG)
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // received bytes go to the buffer; the frame is closed by the ctrl register
  assign mem.we    = wr_go && aw_q == REG_RX && wstrb_q[0] && state == ST_IDLE && !frame_cnt[3];
  assign mem.waddr = frame_cnt[BUF_AW-1:0];
  assign mem.wdata = w_q[7:0];
  assign mem.raddr = rd_idx;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_cnt <= 4'h0;
      overflow  <= 1'b0;
    end
    else if (state == ST_DONE)
    begin
      frame_cnt <= 4'h0;
      overflow  <= 1'b0;
    end
    else if (wr_go && aw_q == REG_RX && wstrb_q[0] && state == ST_IDLE)
    begin
      if (frame_cnt[3])
        overflow <= 1'b1;
      else
        frame_cnt <= frame_cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      node_addr <= RST_NODE_ADDR;
    else if (wr_go && aw_q == REG_ADDR && wstrb_q[0] && addr_ok(w_q[7:0]))
      node_addr <= w_q[7:0];
  end

  // frame interpreter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state  <= ST_IDLE;
      rd_idx <= 3'h0;
      rx_len <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (wr_go && aw_q == REG_CTRL && wstrb_q[0] && w_q[0] && !resp_ready)
          begin
            rx_len <= overflow ? 4'hf : frame_cnt;
            rd_idx <= 3'h0;
            state  <= ST_FETCH;
          end
        ST_FETCH:
          state <= ST_WAIT;
        ST_WAIT:
          state <= ST_LATCH;
        ST_LATCH:
        begin
          if (rd_idx == 3'h3)
            state <= ST_EXEC;
          else
          begin
            rd_idx <= rd_idx + 3'h1;
            state  <= ST_WAIT;
          end
        end
        ST_EXEC:
          state <= ST_DONE;
        ST_DONE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req[0] <= 8'h00;
      req[1] <= 8'h00;
      req[2] <= 8'h00;
      req[3] <= 8'h00;
    end
    else if (state == ST_LATCH)
      req[rd_idx[1:0]] <= mem.rdata;
  end

  // decode and answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch_enable   <= RST_CH_EN;
      misc        <= RST_MISC;
      filter_50hz <= RST_MISC[MISC_FILT_BIT];
      fast_mode   <= RST_MISC[MISC_MODE_BIT];
      resp[0]     <= 8'h00;
      resp[1]     <= 8'h00;
      resp[2]     <= 8'h00;
      resp[3]     <= 8'h00;
      resp_len    <= 3'h0;
      resp_ready  <= 1'b0;
      resp_drop   <= 1'b0;
    end
    else if (state == ST_EXEC)
    begin
      resp[0]    <= req[0];
      resp[1]    <= FUNC_CODE;
      resp[2]    <= req[2];
      resp_ready <= 1'b1;
      resp_drop  <= 1'b0;
      if (rx_len < LEN_RD || req[0] != node_addr || req[1] != FUNC_CODE)
      begin
        resp_drop <= 1'b1;
        resp_len  <= 3'h0;
      end
      else if (req[2] == SUB_RD_MASK || req[2] == SUB_RD_MISC)
      begin
        if (rx_len != LEN_RD)
        begin
          resp[1]  <= FUNC_EXC;
          resp[2]  <= EXC_CODE;
          resp_len <= 3'h3;
        end
        else
        begin
          resp[3]  <= (req[2] == SUB_RD_MASK) ? {4'h0, ch_enable} : misc;
          resp_len <= 3'h4;
        end
      end
      else if (req[2] == SUB_WR_MASK)
      begin
        if (rx_len != LEN_WR || req[3] > MASK_MAX)
        begin
          resp[1]  <= FUNC_EXC;
          resp[2]  <= EXC_CODE;
          resp_len <= 3'h3;
        end
        else
        begin
          ch_enable <= req[3][3:0];
          resp[3]   <= STATUS_OK;
          resp_len  <= 3'h4;
        end
      end
      else if (req[2] == SUB_WR_MISC)
      begin
        if (rx_len != LEN_WR || (req[3] & MISC_RSV_MASK) != 8'h00)
        begin
          resp[1]  <= FUNC_EXC;
          resp[2]  <= EXC_CODE;
          resp_len <= 3'h3;
        end
        else
        begin
          misc        <= req[3];
          filter_50hz <= req[3][MISC_FILT_BIT];
          fast_mode   <= req[3][MISC_MODE_BIT];
          resp[3]     <= STATUS_OK;
          resp_len    <= 3'h4;
        end
      end
      else
      begin
        resp_drop <= 1'b1;
        resp_len  <= 3'h0;
      end
    end
    else if (wr_go && aw_q == REG_CTRL && wstrb_q[0] && w_q[1])
    begin
      // a stale drop flag would end the next status poll early
      resp_ready <= 1'b0;
      resp_drop  <= 1'b0;
    end
  end

  // register read side
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    if (s_axi_araddr == REG_RX)
      next_rdata = {28'h0000_000, frame_cnt};
    else if (s_axi_araddr == REG_CTRL)
      next_rdata = 32'h0000_0000;
    else if (s_axi_araddr == REG_TX)
      next_rdata = {resp[3], resp[2], resp[1], resp[0]};
    else if (s_axi_araddr == REG_STATUS)
      next_rdata = {24'h0000_00, overflow, (state != ST_IDLE), resp_drop, resp_ready, 1'b0, resp_len};
    else if (s_axi_araddr == REG_ADDR)
      next_rdata = {24'h0000_00, node_addr};
    else if (s_axi_araddr == REG_CONFIG)
      next_rdata = {16'h0000, misc, 4'h0, ch_enable};
    else
      next_rerr = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  mask_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_WR_MASK
     && rx_len == LEN_WR && req[3] <= MASK_MAX) |=> ch_enable == $past(req[3][3:0]))
    else $error("enable mask not applied");

  mask_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_WR_MASK
     && rx_len >= LEN_RD && req[3] > MASK_MAX)
     |=> resp[1] == FUNC_EXC && resp[2] == EXC_CODE && $stable(ch_enable))
    else $error("bad mask not rejected");

  misc_reject_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_WR_MISC
     && rx_len >= LEN_RD && (req[3] & MISC_RSV_MASK) != 8'h00) |=> resp[1] == FUNC_EXC && $stable(misc))
    else $error("reserved misc bits accepted");

  rd_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_RD_MISC
     && rx_len == LEN_WR) |=> resp[1] == FUNC_EXC && resp_len == 3'h3)
    else $error("wrong length read not rejected");

  read_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_RD_MASK
     && rx_len == LEN_RD) |=> resp[3] == {4'h0, $past(ch_enable)} && resp[2] == SUB_RD_MASK)
    else $error("mask readback wrong");

  mode_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    filter_50hz == misc[MISC_FILT_BIT] && fast_mode == misc[MISC_MODE_BIT])
    else $error("filter or mode output differs from settings");

  addr_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] != node_addr) |=> resp_drop && resp_len == 3'h0)
    else $error("foreign address answered");

  write_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_EXEC && req[0] == node_addr && req[1] == FUNC_CODE && req[2] == SUB_WR_MISC
     && rx_len == LEN_WR && (req[3] & MISC_RSV_MASK) == 8'h00)
     |=> resp_len == 3'h4 && resp[1] == FUNC_CODE && resp[2] == SUB_WR_MISC && resp[3] == STATUS_OK
     && misc == $past(req[3]))
    else $error("write status not zero");

endmodule : mcc_cmd

// *** design/mcc_frame_mem.sv ***
`timescale 1ns/1ps
module mcc_frame_mem
  import mcc_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH,
  parameter int AW    = BUF_AW
)
(
  // clock
  input wire logic aclk,
  // port
  mcc_mem_if.mem   mp
);
  logic [7:0] store [DEPTH];

  always_ff @(posedge aclk)
  begin
    if (mp.we)
      store[mp.waddr] <= mp.wdata;
  end

  always_ff @(posedge aclk)
  begin
    mp.rdata <= store[mp.raddr];
  end
endmodule : mcc_frame_mem

// *** inc/mcc_mem_if.sv ***
`timescale 1ns/1ps
interface mcc_mem_if #(parameter int AW = 3);
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mcc_mem_if

// *** inc/mcc_pkg.sv ***
package mcc_pkg;

  // frame bytes
  localparam logic [7:0] FUNC_CODE     = 8'h46;
  localparam logic [7:0] FUNC_EXC      = 8'hc6;
  localparam logic [7:0] EXC_CODE      = 8'h03;
  localparam logic [7:0] SUB_RD_MASK   = 8'h25;
  localparam logic [7:0] SUB_WR_MASK   = 8'h26;
  localparam logic [7:0] SUB_RD_MISC   = 8'h29;
  localparam logic [7:0] SUB_WR_MISC   = 8'h2a;
  localparam logic [7:0] STATUS_OK     = 8'h00;
  localparam logic [7:0] MASK_MAX      = 8'h0f;
  localparam logic [7:0] MISC_RSV_MASK = 8'h5f;
  localparam int         MISC_FILT_BIT = 7;
  localparam int         MISC_MODE_BIT = 5;
  localparam logic [7:0] ADDR_MIN      = 8'h01;
  localparam logic [7:0] ADDR_MAX      = 8'hf7;

  // request lengths in bytes
  localparam logic [3:0] LEN_RD = 4'h3;
  localparam logic [3:0] LEN_WR = 4'h4;

  // request buffer
  localparam int         BUF_DEPTH = 8;
  localparam int         BUF_AW    = 3;

  // register byte addresses
  localparam logic [7:0] REG_RX      = 8'h00;
  localparam logic [7:0] REG_CTRL    = 8'h04;
  localparam logic [7:0] REG_TX      = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_ADDR    = 8'h10;
  localparam logic [7:0] REG_CONFIG  = 8'h14;

  // reset values
  localparam logic [7:0] RST_NODE_ADDR = 8'h01;
  localparam logic [3:0] RST_CH_EN     = 4'hf;
  localparam logic [7:0] RST_MISC      = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : mcc_pkg

// *** testbench/mcc_host.sv ***
`timescale 1ns/1ps
module mcc_host
  import mcc_pkg::*;
(
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      // released data no longer shows the last value
      if (s_axi_wvalid && s_axi_wready) s_axi_wdata <= ~s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask : rd

  // frame bytes go out in order: address, function, sub-function, data
  task automatic transact(input logic [7:0] req[$], output logic [7:0] st, output logic [31:0] tx);
    logic [1:0]  r;
    logic [31:0] d;
    foreach (req[i]) wr(REG_RX, {24'h0, req[i]}, r);
    wr(REG_CTRL, 32'h1, r);
    st = 8'h00;
    while (!(st[4] | st[5]))
    begin
      rd(REG_STATUS, d, r);
      st = d[7:0];
    end
    tx = 32'h0;
    if (st[4])
    begin
      rd(REG_TX, tx, r);
      wr(REG_CTRL, 32'h2, r);
    end
  endtask : transact
endmodule : mcc_host

// *** testbench/modbus_channel_misc_config_cmds_test.sv ***
`timescale 1ns/1ps
module modbus_channel_misc_config_cmds_test
  import mcc_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, ch_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, filter_50hz, fast_mode;
  int          errors = 0;
  int          checked = 0;
  logic [7:0]  vals[4] = '{8'h20, 8'h0f, 8'h85, 8'ha0};

  always #50 aclk = ~aclk;

  mcc_cmd mcc_cmd_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch_enable,
    .filter_50hz, .fast_mode);

  mcc_host mcc_host_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic complete_run();
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk

  task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$]);
    logic [7:0]  st;
    logic [31:0] tx;
    mcc_host_i.transact(req, st, tx);
    chk(32'(st[2:0]), 32'(exp.size()));
    foreach (exp[i]) chk(32'(tx[8*i+:8]), 32'(exp[i]));
  endtask : run

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    mcc_host_i.rd(REG_CONFIG, d, r);
    chk(d, 32'h0000000f);
    chk({ch_enable, filter_50hz, fast_mode}, 6'h3c);
    run({8'h01, 8'h46, 8'h25}, {8'h01, 8'h46, 8'h25, 8'h0f});
  endtask : t_reset

  task automatic t_mask();
    foreach (vals[i])
    begin
      run({8'h01, 8'h46, 8'h26, vals[i] & 8'h0f}, {8'h01, 8'h46, 8'h26, 8'h00});
      chk(32'(ch_enable), 32'(vals[i][3:0]));
      run({8'h01, 8'h46, 8'h25}, {8'h01, 8'h46, 8'h25, vals[i] & 8'h0f});
    end
    run({8'h01, 8'h46, 8'h26, 8'h15}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h26}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h26, 8'h03, 8'h00}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h25, 8'h00}, {8'h01, 8'hc6, 8'h03});
    chk(32'(ch_enable), 32'h0);
  endtask : t_mask

  task automatic t_misc();
    logic [31:0] d;
    logic [1:0]  r;
    // legal settings keep the reserved bits at zero
    foreach (vals[i])
    begin
      run({8'h01, 8'h46, 8'h2a, vals[i] & 8'ha0}, {8'h01, 8'h46, 8'h2a, 8'h00});
      chk({filter_50hz, fast_mode}, {vals[i][7], vals[i][5]});
      run({8'h01, 8'h46, 8'h29}, {8'h01, 8'h46, 8'h29, vals[i] & 8'ha0});
    end
    run({8'h01, 8'h46, 8'h2a, 8'h40}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h2a, 8'h01}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h2a}, {8'h01, 8'hc6, 8'h03});
    run({8'h01, 8'h46, 8'h29, 8'h00}, {8'h01, 8'hc6, 8'h03});
    mcc_host_i.rd(REG_CONFIG, d, r);
    chk(d, 32'h0000a000);
    chk({filter_50hz, fast_mode}, 2'b11);
  endtask : t_misc

  task automatic t_addr();
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  st;
    mcc_host_i.wr(REG_ADDR, 32'hf8, r);
    chk(32'(r), 32'(RESP_OKAY));
    mcc_host_i.wr(REG_ADDR, 32'hf7, r);
    mcc_host_i.wr(REG_ADDR, 32'h00, r);
    mcc_host_i.rd(REG_ADDR, d, r);
    chk(32'(d[7:0]), 32'hf7);
    run({8'hf7, 8'h46, 8'h25}, {8'hf7, 8'h46, 8'h25, 8'h00});
    mcc_host_i.rd(8'h18, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    mcc_host_i.wr(8'h18, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    mcc_host_i.transact({8'h01, 8'h46, 8'h26, 8'h0f}, st, d);
    chk(32'(st[5:4]), 32'h3);
    chk(32'(st[2:0]), 32'h0);
    chk(32'(ch_enable), 32'h0);
  endtask : t_addr

  initial
  begin
    #(100 * 40000);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_misc();
    t_addr();
    complete_run();
  end
endmodule : modbus_channel_misc_config_cmds_test
